// [hdl/wdw_pkg.sv]
// constants and types for the windowed watchdog register block
package wdw_pkg;
   localparam logic [7:0] CTRL_INDEX = 8'h00;
   localparam logic [7:0] STATE_INDEX = 8'h01;
   localparam logic [9:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
   localparam logic [9:0] STATE_ADDR = {STATE_INDEX, 2'b00};
   localparam logic [7:0] STATE_RESET = 8'h00;
   localparam int LOCK_BIT = 7;
   localparam int PENDING_BIT = 0;
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_MAX = 4'hB;
   localparam logic [13:0] BASE_CYCLES = 14'h0008;
   localparam logic [2:0] GUARD_WINDOW = 3'h4;
   localparam logic [1:0] SYNC_TICKS = 2'h3;
   localparam logic [1:0] RESTART_TICKS = 2'h2;
   typedef struct packed {
      logic [3:0] window;
      logic [3:0] period;
   } wdw_ctrl_t;
   typedef enum logic [1:0] {IDLE, NORMAL, CLOSED, OPEN} wdw_phase_t;
endpackage

// [hdl/wdw_regs.sv]
// windowed watchdog: apb registers, guarded writes, sync model and timer
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module wdw_regs
(
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] boot_config_word,
   input wire logic boot_done,
   input wire logic debug_mode,
   input wire logic protected_write_guard,
   input wire logic slow_tick,
   input wire logic watchdog_restart_instr,
   output logic system_reset
);
   wdw_pkg::wdw_ctrl_t ctrl_shadow;
   wdw_pkg::wdw_ctrl_t ctrl_live;
   wdw_pkg::wdw_phase_t phase;
   logic lock;
   logic pending;
   logic [1:0] sync_cnt;
   logic [2:0] guard_cnt;
   logic restart_busy;
   logic [1:0] restart_cnt;
   logic [13:0] count;
   logic [13:0] period_len;
   logic [13:0] window_len;
   logic access;
   logic hit_ctrl;
   logic hit_state;
   logic guard_ok;
   logic ctrl_wr_ok;
   logic lock_wr_ok;
   logic sync_done;
   logic restart_apply;

   function automatic logic [13:0] wdw_len(input logic [3:0] code);
      logic [3:0] c;
      c = (code > wdw_pkg::CODE_MAX) ? wdw_pkg::CODE_MAX : code;
      wdw_len = wdw_pkg::BASE_CYCLES << (c - 4'h1);
   endfunction

   assign access = psel && penable && pready;
   assign hit_ctrl = paddr[9:0] == wdw_pkg::CTRL_ADDR && paddr[31:10] == '0;
   assign hit_state = paddr[9:0] == wdw_pkg::STATE_ADDR && paddr[31:10] == '0;
   assign guard_ok = guard_cnt != 3'h0;
   // writes while pending are dropped so the slow side never sees a torn value
   assign ctrl_wr_ok = access && pwrite && hit_ctrl && guard_ok && !lock && !pending;
   assign lock_wr_ok = access && pwrite && hit_state && guard_ok && pwdata[wdw_pkg::LOCK_BIT];
   assign sync_done = pending && slow_tick && sync_cnt == wdw_pkg::SYNC_TICKS - 2'h1;
   assign restart_apply = restart_busy && slow_tick && restart_cnt == wdw_pkg::RESTART_TICKS - 2'h1;
   assign period_len = wdw_len(ctrl_live.period);
   assign window_len = wdw_len(ctrl_live.window);

   // apb answer: one wait state, registered
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !(hit_ctrl || hit_state);
         prdata <= '0;
         if (psel && penable && !pready && hit_ctrl)
            prdata <= {24'h0, ctrl_shadow};
         else if (psel && penable && !pready && hit_state)
            prdata <= {24'h0, lock, 6'h0, pending};
      end
   end

   // guard window: opened by the unlock key, consumed by a protected write
   always_ff @(posedge clock)
   begin
      if (reset)
         guard_cnt <= 3'h0;
      else if (protected_write_guard)
         guard_cnt <= wdw_pkg::GUARD_WINDOW;
      else if (ctrl_wr_ok || lock_wr_ok)
         guard_cnt <= 3'h0;
      else if (guard_ok)
         guard_cnt <= guard_cnt - 3'h1;
   end

   // control shadow, loaded from the boot word under reset
   always_ff @(posedge clock)
   begin
      if (reset)
         ctrl_shadow <= boot_config_word;
      else if (ctrl_wr_ok)
         ctrl_shadow <= pwdata[7:0];
   end

   // lock: set wins over the debug clear
   always_ff @(posedge clock)
   begin
      if (reset)
         lock <= 1'b0;
      else if (lock_wr_ok || (boot_done && ctrl_shadow.period != wdw_pkg::CODE_OFF))
         lock <= 1'b1;
      else if (debug_mode)
         lock <= 1'b0;
   end

   // transfer model: value reaches the slow side after a fixed number of ticks
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pending <= 1'b0;
         sync_cnt <= 2'h0;
         ctrl_live <= boot_config_word;
      end
      else if (ctrl_wr_ok)
      begin
         pending <= 1'b1;
         sync_cnt <= 2'h0;
      end
      else if (sync_done)
      begin
         pending <= 1'b0;
         ctrl_live <= ctrl_shadow;
      end
      else if (pending && slow_tick)
         sync_cnt <= sync_cnt + 2'h1;
   end

   // restart synchroniser; a second restart while busy is dropped
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         restart_busy <= 1'b0;
         restart_cnt <= 2'h0;
      end
      else if (!restart_busy)
      begin
         restart_busy <= watchdog_restart_instr;
         restart_cnt <= 2'h0;
      end
      else if (restart_apply)
         restart_busy <= 1'b0;
      else if (slow_tick)
         restart_cnt <= restart_cnt + 2'h1;
   end

   // timer phases and counter; the count advances only on slow ticks
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         phase <= wdw_pkg::IDLE;
         count <= '0;
         system_reset <= 1'b0;
      end
      else
      begin
         system_reset <= 1'b0;
         if (ctrl_live.period == wdw_pkg::CODE_OFF)
         begin
            phase <= wdw_pkg::IDLE;
            count <= '0;
         end
         else if (sync_done || debug_mode || phase == wdw_pkg::IDLE)
         begin
            // first window after enable or debug waits for a restart
            phase <= wdw_pkg::NORMAL;
            count <= '0;
         end
         else if (restart_apply)
         begin
            count <= '0;
            if (phase == wdw_pkg::CLOSED)
               system_reset <= 1'b1;
            else if (ctrl_live.window != wdw_pkg::CODE_OFF)
               phase <= wdw_pkg::CLOSED;
            else
               phase <= wdw_pkg::NORMAL;
         end
         else if (slow_tick)
         begin
            count <= count + 14'h0001;
            if (phase == wdw_pkg::CLOSED && count == window_len - 14'h0001)
            begin
               phase <= wdw_pkg::OPEN;
               count <= '0;
            end
            else if (phase != wdw_pkg::CLOSED && count == period_len - 14'h0001)
            begin
               system_reset <= 1'b1;
               count <= '0;
            end
         end
      end
   end

   AST_LOCK_BLOCKS_CTRL: assert property (@(posedge clock) disable iff (reset)
      lock && access && pwrite && hit_ctrl |=> $stable(ctrl_shadow))
      else $error("control changed while locked");
   AST_LOCK_STICKS: assert property (@(posedge clock) disable iff (reset)
      lock && !debug_mode |=> lock)
      else $error("lock cleared outside debug");
   AST_BOOT_LOCK: assert property (@(posedge clock) disable iff (reset)
      boot_done && ctrl_shadow.period != wdw_pkg::CODE_OFF |=> lock)
      else $error("boot lock missing");
   AST_UNGUARDED_LOCK: assert property (@(posedge clock) disable iff (reset)
      !lock && guard_cnt == 3'h0 && !boot_done |=> !lock)
      else $error("lock set without guard");
   AST_PENDING_SET: assert property (@(posedge clock) disable iff (reset)
      ctrl_wr_ok |=> pending && ctrl_shadow == $past(pwdata[7:0]))
      else $error("pending flag not set");
   AST_PENDING_CLEAR: assert property (@(posedge clock) disable iff (reset)
      sync_done |=> !pending && ctrl_live == ctrl_shadow)
      else $error("pending flag not cleared");
   AST_STATE_READ: assert property (@(posedge clock) disable iff (reset)
      psel && penable && !pready && hit_state |=> prdata[0] == $past(pending) && pready)
      else $error("status read wrong");
   AST_DISABLED: assert property (@(posedge clock) disable iff (reset)
      ctrl_live.period == wdw_pkg::CODE_OFF |=> phase == wdw_pkg::IDLE && !system_reset)
      else $error("watchdog active when off");
   AST_CLOSED_RESTART: assert property (@(posedge clock) disable iff (reset)
      restart_apply && phase == wdw_pkg::CLOSED && !debug_mode && !sync_done
      && ctrl_live.period != wdw_pkg::CODE_OFF |=> system_reset)
      else $error("closed window restart missed");
   AST_TIMEOUT: assert property (@(posedge clock) disable iff (reset)
      phase == wdw_pkg::NORMAL && slow_tick && count == period_len - 14'h0001
      && !restart_apply && !sync_done && !debug_mode
      && ctrl_live.period != wdw_pkg::CODE_OFF |=> system_reset)
      else $error("timeout did not reset");
   AST_RESTART_DROP: assert property (@(posedge clock) disable iff (reset)
      restart_busy && !restart_apply |=> restart_busy && restart_cnt >= $past(restart_cnt))
      else $error("restart resynchronised");

   // checks on the guard, the bus answer, the transfer model and the timer phases
   AST_ZERO_LOCK_WRITE: assert property (@(posedge clock) disable iff (reset)
      !lock && !boot_done && access && pwrite && hit_state
      && !pwdata[wdw_pkg::LOCK_BIT] |=> !lock)
      else $error("lock set by a zero write");
   AST_GUARD_USED: assert property (@(posedge clock) disable iff (reset)
      (ctrl_wr_ok || lock_wr_ok) && !protected_write_guard |=> guard_cnt == 3'h0)
      else $error("guard window not consumed");
   // the slow side must never see a half-applied control value
   AST_LIVE_HELD: assert property (@(posedge clock) disable iff (reset)
      !sync_done |=> $stable(ctrl_live))
      else $error("live control changed mid transfer");
   AST_PENDING_HOLD: assert property (@(posedge clock) disable iff (reset)
      pending && !sync_done |=> pending)
      else $error("pending flag dropped early");
   AST_ANSWER: assert property (@(posedge clock) disable iff (reset)
      psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   AST_UNMAPPED: assert property (@(posedge clock) disable iff (reset)
      psel && penable && !pready && !hit_ctrl && !hit_state |=> pslverr && prdata == '0)
      else $error("unmapped access not refused");
   AST_RESTART_TAKEN: assert property (@(posedge clock) disable iff (reset)
      !restart_busy && watchdog_restart_instr |=> restart_busy)
      else $error("restart request lost");
   AST_RESTART_CLEARS: assert property (@(posedge clock) disable iff (reset)
      restart_apply |=> count == 14'h0000)
      else $error("counter kept after restart");
   AST_CLOSED_TO_OPEN: assert property (@(posedge clock) disable iff (reset)
      phase == wdw_pkg::CLOSED && slow_tick && count == window_len - 14'h0001
      && !restart_apply && !sync_done && !debug_mode
      && ctrl_live.period != wdw_pkg::CODE_OFF |=> phase == wdw_pkg::OPEN)
      else $error("open window did not follow closed window");
   AST_OPEN_RESTART: assert property (@(posedge clock) disable iff (reset)
      restart_apply && phase == wdw_pkg::OPEN && !sync_done && !debug_mode
      && ctrl_live.period != wdw_pkg::CODE_OFF |=> !system_reset && phase == wdw_pkg::CLOSED)
      else $error("open window restart refused");

   COV_CTRL_WRITE: cover property (@(posedge clock) disable iff (reset) ctrl_wr_ok);
   COV_LOCK_SET: cover property (@(posedge clock) disable iff (reset) lock_wr_ok && !lock);
   COV_OPEN: cover property (@(posedge clock) disable iff (reset) phase == wdw_pkg::OPEN);
   COV_RESET: cover property (@(posedge clock) disable iff (reset) system_reset);
   COV_OPEN_RESTART: cover property (@(posedge clock) disable iff (reset)
      restart_apply && phase == wdw_pkg::OPEN);
endmodule

// [bench/wdw_regs_tb.sv]
// self-checking bench for the windowed watchdog register block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h want %h", $time, a, e); end end
module wdw_regs_tb;
   localparam logic [31:0] CA = {22'h0, wdw_pkg::CTRL_ADDR};
   localparam logic [31:0] SA = {22'h0, wdw_pkg::STATE_ADDR};
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] boot_word = 8'h25;
   logic boot_done = 1'b0;
   logic debug_mode = 1'b0;
   logic guard = 1'b0;
   logic slow_tick = 1'b0;
   logic restart = 1'b0;
   logic system_reset;
   logic [1:0] tdiv = 2'h0;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int checks_done = 0;
   int sr_cnt = 0;
   int s0;
   wdw_regs wdw_regs_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .boot_config_word(boot_word), .boot_done(boot_done),
      .debug_mode(debug_mode), .protected_write_guard(guard), .slow_tick(slow_tick),
      .watchdog_restart_instr(restart), .system_reset(system_reset));
   initial forever #2 clock = ~clock;
   // slow clock enable every fourth system clock keeps timeouts short
   always @(posedge clock)
   begin
      tdiv <= tdiv + 2'h1;
      slow_tick <= (tdiv == 2'h3);
      if (system_reset === 1'b1)
         sr_cnt <= sr_cnt + 1;
   end
   task close_out;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // guard pulse rides on the setup cycle so the write lands well inside its window
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic g);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      guard <= g;
      @(posedge clock);
      penable <= 1'b1;
      guard <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40)
      begin
         error_cnt++;
         $display("[ERR] %0t no pready", $time);
         close_out();
      end
   endtask
   task ticks(input int n);
      int w;
      repeat (n)
      begin
         w = 0;
         @(posedge clock);
         while (slow_tick !== 1'b1 && w < 8)
         begin
            @(posedge clock);
            w++;
         end
         if (w >= 8)
         begin
            error_cnt++;
            $display("[ERR] %0t no slow tick", $time);
            close_out();
         end
      end
   endtask
   task kick;
      @(posedge clock);
      restart <= 1'b1;
      @(posedge clock);
      restart <= 1'b0;
   endtask
   task sc_idle_regs;
      apb(0, CA, 0, 0); `CHK(rd, 32'h0000_0025)
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0000)
      apb(0, 32'h0000_0008, 0, 0); `CHK({err, rd}, {1'b1, 32'h0})
      apb(1, SA, 32'h0000_0001, 0);
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0000)
      apb(1, CA, 32'h0000_0001, 0);
      apb(0, CA, 0, 0); `CHK(rd, 32'h0000_0025)
   endtask
   task sc_sync_normal;
      apb(1, CA, 32'h0000_0001, 1);
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0001)
      ticks(4);
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0000)
      apb(0, CA, 0, 0); `CHK(rd, 32'h0000_0001)
      s0 = sr_cnt;
      repeat (5)
      begin
         kick();
         ticks(4);
      end
      `CHK(sr_cnt, s0)
      ticks(12);
      `CHK(sr_cnt > s0, 1'b1)
   endtask
   task sc_window;
      apb(1, CA, 32'h0000_0011, 1);
      ticks(4);
      kick();
      kick();
      s0 = sr_cnt;
      ticks(3);
      `CHK(sr_cnt, s0)
      ticks(8);
      kick();
      ticks(3);
      `CHK(sr_cnt, s0)
      kick();
      ticks(3);
      `CHK(sr_cnt > s0, 1'b1)
   endtask
   task sc_disable;
      apb(1, CA, 32'h0000_0000, 1);
      ticks(4);
      apb(0, CA, 0, 0); `CHK(rd, 32'h0000_0000)
      s0 = sr_cnt;
      ticks(20);
      `CHK(sr_cnt, s0)
   endtask
   task sc_lock;
      apb(1, SA, 32'h0000_0080, 0);
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0000)
      apb(1, SA, 32'h0000_0080, 1);
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0080)
      apb(1, CA, 32'h0000_0005, 1);
      apb(0, CA, 0, 0); `CHK(rd, 32'h0000_0011)
      apb(1, SA, 32'h0000_0000, 1);
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0080)
      @(posedge clock);
      debug_mode <= 1'b1;
      @(posedge clock);
      debug_mode <= 1'b0;
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0000)
   endtask
   task sc_boot_lock;
      @(posedge clock);
      reset <= 1'b1;
      boot_word <= 8'h03;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0000)
      @(posedge clock);
      boot_done <= 1'b1;
      @(posedge clock);
      boot_done <= 1'b0;
      apb(0, SA, 0, 0); `CHK(rd, 32'h0000_0080)
      apb(0, CA, 0, 0); `CHK(rd, 32'h0000_0003)
   endtask
   initial
   begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      sc_idle_regs();
      sc_sync_normal();
      sc_window();
      sc_lock();
      sc_disable();
      sc_boot_lock();
      close_out();
   end
endmodule
